// ### rtl/bga_gpio_top.sv
/*
  GPIO alternate-function logic of a USB-to-SPI bridge: read gating,
  event counter, clock output, SPI activity, suspend indicators,
  remote wakeup, suspend override and one-time configuration locking.
  Assumes USB state, SPI status and host requests arrive on i_clk;
  pin levels arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module bga_gpio_top #(
  parameter int WAKE_CYCLES = bga_pkg::WAKE_CYC,
  parameter int ACT_CYCLES  = bga_pkg::ACT_CYC
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic [bga_pkg::NPIN-1:0]    i_gpio,
  input  wire logic [bga_pkg::NPIN-1:0]    i_gpio_latch,
  input  wire logic                        i_read_cmd,
  input  wire logic                        i_flow_en,
  input  wire logic                        i_spi_busy,
  input  wire logic                        i_enumerated,
  input  wire logic                        i_suspend,
  input  wire logic                        i_evt_query,
  input  wire logic                        i_otp_wr,
  input  wire logic [3:0]                  i_otp_item,
  input  wire logic [15:0]                 i_otp_data,
  output var  logic [bga_pkg::NPIN-1:0]    o_gpio_out,
  output var  logic [bga_pkg::NPIN-1:0]    o_gpio_oe,
  output var  logic                        o_read_clock_ok,
  output var  logic [bga_pkg::CNT_W-1:0]   o_evt_value,
  output var  logic                        o_evt_valid,
  output var  logic                        o_remote_wake,
  output var  logic                        o_otp_accept,
  output var  logic                        o_otp_reject,
  output var  logic [bga_pkg::NGROUP-1:0]  o_otp_locked
);
  import bga_pkg::*;

  typedef enum logic [1:0] {
    WK_IDLE,
    WK_SIGNAL,
    WK_DONE
  } bga_wake_state_type;

  localparam int WK_W  = $clog2(WAKE_CYCLES + 1);
  localparam int ACT_W = $clog2(ACT_CYCLES + 1);

  // configuration store
  logic [NPIN-1:0]   cfg_func;
  logic [NPIN-1:0]   cfg_dir;
  logic [NPIN-1:0]   cfg_pp;
  logic [OPT_W-1:0]  cfg_opt;
  logic [NPIN-1:0]   cfg_smode;
  logic [NPIN-1:0]   cfg_slatch;
  logic [NPIN-1:0]   cfg_wmask;
  logic [NPIN-1:0]   cfg_wval;
  logic [DIV_W-1:0]  cfg_div;
  logic [NGROUP-1:0] locked;

  // pin synchroniser
  logic [NPIN-1:0]   gpio_meta;
  logic [NPIN-1:0]   gpio_sync;

  // alternate function state
  logic              gate_asserted;
  logic              clk_run;
  logic              clk_wave;
  logic              act_level;
  logic [ACT_W-1:0]  act_cnt;
  logic              susp_q;
  logic              mismatch;
  bga_wake_state_type wk_state;
  logic [WK_W-1:0]   wk_cnt;

  // per-pin drive
  logic [NPIN-1:0]   alt_val;
  logic [NPIN-1:0]   norm_val;
  logic [NPIN-1:0]   next_out;
  logic [NPIN-1:0]   next_oe;

  // one-time write decode
  logic [1:0]        wr_group;
  logic              wr_valid;

  bga_evt_if evt ();

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gpio_meta <= '0;
      gpio_sync <= '0;
    end else begin
      gpio_meta <= i_gpio;
      gpio_sync <= gpio_meta;
    end
  end

  // item to group; unknown items map to no group and are refused
  always_comb begin
    wr_valid = 1'b1;
    unique case (i_otp_item)
      ITEM_FUNC, ITEM_DIR, ITEM_PP, ITEM_OPT:       wr_group = 2'h0;
      ITEM_SMODE, ITEM_SLATCH, ITEM_WMASK, ITEM_WVAL: wr_group = 2'h1;
      ITEM_DIV:                                      wr_group = 2'h2;
      default: begin
        wr_group = 2'h0;
        wr_valid = 1'b0;
      end
    endcase
  end

  // one-time configuration: first write to a group locks all its items
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      locked       <= '0;
      o_otp_accept <= 1'b0;
      o_otp_reject <= 1'b0;
    end else begin
      o_otp_accept <= 1'b0;
      o_otp_reject <= 1'b0;
      if (i_otp_wr) begin
        if (!wr_valid || locked[wr_group]) begin
          o_otp_reject <= 1'b1;
        end else begin
          locked[wr_group] <= 1'b1;
          o_otp_accept     <= 1'b1;
        end
      end
    end
  end

  assign o_otp_locked = locked;

  // locked state survives only until power-on reset in this model
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_func   <= DEF_FUNC;
      cfg_dir    <= DEF_DIR;
      cfg_pp     <= DEF_PP;
      cfg_opt    <= DEF_OPT;
      cfg_smode  <= DEF_SMODE;
      cfg_slatch <= DEF_SLATCH;
      cfg_wmask  <= DEF_WMASK;
      cfg_wval   <= DEF_WVAL;
      cfg_div    <= DEF_DIV;
    end else if (i_otp_wr && wr_valid && !locked[wr_group]) begin
      unique case (i_otp_item)
        ITEM_FUNC:   cfg_func   <= i_otp_data[NPIN-1:0];
        ITEM_DIR:    cfg_dir    <= i_otp_data[NPIN-1:0];
        ITEM_PP:     cfg_pp     <= i_otp_data[NPIN-1:0];
        ITEM_OPT:    cfg_opt    <= i_otp_data[OPT_W-1:0];
        ITEM_SMODE:  cfg_smode  <= i_otp_data[NPIN-1:0];
        ITEM_SLATCH: cfg_slatch <= i_otp_data[NPIN-1:0];
        ITEM_WMASK:  cfg_wmask  <= i_otp_data[NPIN-1:0];
        ITEM_WVAL:   cfg_wval   <= i_otp_data[NPIN-1:0];
        default:     cfg_div    <= i_otp_data[DIV_W-1:0];
      endcase
    end
  end

  // read gate: polarity xor, then qualified by function and flow enable
  assign gate_asserted = cfg_opt[OPT_RTR_HIGH] ? gpio_sync[PIN_RTR]
                                               : ~gpio_sync[PIN_RTR];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_read_clock_ok <= 1'b1;
    end else if (i_read_cmd && i_flow_en && cfg_func[PIN_RTR]) begin
      o_read_clock_ok <= gate_asserted;
    end else begin
      o_read_clock_ok <= 1'b1;
    end
  end

  // event counter on pin four
  assign evt.level  = gpio_sync[PIN_EVT];
  assign evt.enable = cfg_func[PIN_EVT];
  assign evt.mode   = bga_evt_mode_type'(cfg_opt[OPT_EVT_LSB +: 2]);

  bga_evt_counter u_evt (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .evt   (evt.cnt)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_evt_value <= '0;
      o_evt_valid <= 1'b0;
    end else begin
      o_evt_valid <= i_evt_query;
      if (i_evt_query) begin
        o_evt_value <= evt.count;
      end
    end
  end

  // clock output: runs only enumerated and awake
  assign clk_run = i_enumerated && !i_suspend && cfg_func[PIN_CLK];

  bga_clk_div u_clk (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_run     (clk_run),
    .i_div     (cfg_div),
    .o_clk_out (clk_wave)
  );

  // activity indicator: idle high, fixed-rate toggle while busy
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_spi_busy) begin
      act_cnt   <= '0;
      act_level <= 1'b1;
    end else if (act_cnt == ACT_W'(ACT_CYCLES - 1)) begin
      act_cnt   <= '0;
      act_level <= ~act_level;
    end else begin
      act_cnt   <= act_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      susp_q <= 1'b0;
    end else begin
      susp_q <= i_suspend;
    end
  end

  // remote wakeup: one signalling burst per suspended period
  assign mismatch = |((gpio_sync ^ cfg_wval) & cfg_wmask);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wk_state      <= WK_IDLE;
      wk_cnt        <= '0;
      o_remote_wake <= 1'b0;
    end else begin
      unique case (wk_state)
        WK_IDLE: begin
          if (i_suspend && mismatch) begin
            wk_state      <= WK_SIGNAL;
            wk_cnt        <= '0;
            o_remote_wake <= 1'b1;
          end
        end
        WK_SIGNAL: begin
          if (wk_cnt == WK_W'(WAKE_CYCLES - 1)) begin
            wk_state      <= WK_DONE;
            o_remote_wake <= 1'b0;
          end else begin
            wk_cnt        <= wk_cnt + 1'b1;
          end
        end
        WK_DONE: begin
          if (!i_suspend) begin
            wk_state <= WK_IDLE;
          end
        end
      endcase
    end
  end

  // alternate values; pins 3 and 4 are inputs so their value is unused
  always_comb begin
    alt_val            = i_gpio_latch;
    alt_val[PIN_CLK]   = clk_wave;
    alt_val[PIN_ACT]   = act_level;
    alt_val[PIN_SUSP]  = i_suspend;
    alt_val[PIN_NSUSP] = ~i_suspend;
  end

  assign norm_val = (cfg_func & alt_val) | (~cfg_func & i_gpio_latch);

  // suspend override takes effect in the same edge as suspend entry;
  // wake pins in cfg_wmask are forced to inputs here; outside the override cfg_dir and cfg_pp decide
  always_comb begin
    if (i_suspend && cfg_opt[OPT_USE_SUSP]) begin
      next_out = cfg_slatch;
      next_oe  = (cfg_smode | ~cfg_slatch) & ~cfg_wmask;
    end else begin
      next_out = norm_val;
      next_oe  = cfg_dir & (cfg_pp | ~norm_val);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_gpio_out <= '0;
      o_gpio_oe  <= '0;
    end else begin
      o_gpio_out <= next_out;
      o_gpio_oe  <= next_oe;
    end
  end

endmodule : bga_gpio_top
`default_nettype wire

// ### rtl/bga_pkg.sv
/*
  Shared constants and types for the bridge GPIO alternate-function block:
  pin numbers, configuration item layout, factory defaults, timing counts.
  Assumes a single 20 MHz core clock with synchronous active-high reset.
*/
package bga_pkg;

  localparam int NPIN      = 11;
  localparam int PIN_RTR   = 3;
  localparam int PIN_EVT   = 4;
  localparam int PIN_CLK   = 5;
  localparam int PIN_ACT   = 8;
  localparam int PIN_SUSP  = 9;
  localparam int PIN_NSUSP = 10;

  localparam int CNT_W     = 16;
  localparam int DIV_W     = 8;

  // rates in MHz; divider zero behaves as 256 (24 MHz / 256 = 93.75 kHz)
  localparam int CLK_MHZ      = 20;
  localparam int REF_MHZ      = 24;
  localparam int DIV_ZERO_EQ  = 256;
  localparam int ACC_W        = 14;

  // wakeup signalling, least of the 10..15 ms window
  localparam int WAKE_MS      = 10;
  localparam int WAKE_CYC     = WAKE_MS * CLK_MHZ * 1000;
  // activity indicator half period
  localparam int ACT_HALF_MS  = 50;
  localparam int ACT_CYC      = ACT_HALF_MS * CLK_MHZ * 1000;

  // configuration items written through the one-time port
  localparam logic [3:0] ITEM_FUNC   = 4'h0;
  localparam logic [3:0] ITEM_DIR    = 4'h1;
  localparam logic [3:0] ITEM_PP     = 4'h2;
  localparam logic [3:0] ITEM_OPT    = 4'h3;
  localparam logic [3:0] ITEM_SMODE  = 4'h4;
  localparam logic [3:0] ITEM_SLATCH = 4'h5;
  localparam logic [3:0] ITEM_WMASK  = 4'h6;
  localparam logic [3:0] ITEM_WVAL   = 4'h7;
  localparam logic [3:0] ITEM_DIV    = 4'h8;
  localparam int         NGROUP      = 3;

  // option item fields
  localparam int OPT_RTR_HIGH = 0;
  localparam int OPT_EVT_LSB  = 1;
  localparam int OPT_USE_SUSP = 3;
  localparam int OPT_W        = 4;

  // factory defaults
  localparam logic [NPIN-1:0]  DEF_FUNC   = 11'h738;
  localparam logic [NPIN-1:0]  DEF_DIR    = 11'h7A7;
  localparam logic [NPIN-1:0]  DEF_PP     = 11'h7A7;
  localparam logic [OPT_W-1:0] DEF_OPT    = 4'h0;
  localparam logic [NPIN-1:0]  DEF_SMODE  = 11'h000;
  localparam logic [NPIN-1:0]  DEF_SLATCH = 11'h000;
  localparam logic [NPIN-1:0]  DEF_WMASK  = 11'h000;
  localparam logic [NPIN-1:0]  DEF_WVAL   = 11'h000;
  localparam logic [DIV_W-1:0] DEF_DIV    = 8'h00;

  typedef enum logic [1:0] {
    EVT_RISE,
    EVT_FALL,
    EVT_PPULSE,
    EVT_NPULSE
  } bga_evt_mode_type;

endpackage : bga_pkg

// ### rtl/bga_evt_if.sv
/*
  Carrier between the top and the event counter: sampled pin level,
  enable and mode out, running count back.
  Assumes all members live on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface bga_evt_if;
  import bga_pkg::*;
  logic                   level;
  logic                   enable;
  bga_evt_mode_type       mode;
  logic [CNT_W-1:0]       count;
  modport ctrl (output level, output enable, output mode, input count);
  modport cnt  (input level, input enable, input mode, output count);
endinterface : bga_evt_if
`default_nettype wire

// ### rtl/bga_evt_counter.sv
/*
  16-bit edge / pulse event counter.
  Assumes the level is already synchronised to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bga_evt_counter (
  input  wire logic i_clk,
  input  wire logic i_rst,
  bga_evt_if.cnt    evt
);
  import bga_pkg::*;

  logic prev;
  logic armed;
  logic rise;
  logic fall;
  logic hit;

  assign rise = evt.level & ~prev;
  assign fall = ~evt.level & prev;

  always_comb begin
    unique case (evt.mode)
      EVT_RISE:   hit = rise;
      EVT_FALL:   hit = fall;
      EVT_PPULSE: hit = fall & armed;
      EVT_NPULSE: hit = rise & armed;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev <= 1'b0;
    end else begin
      prev <= evt.level;
    end
  end

  // a pulse counts only once its leading edge was seen while enabled
  always_ff @(posedge i_clk) begin
    if (i_rst || !evt.enable) begin
      armed <= 1'b0;
    end else if ((evt.mode == EVT_PPULSE && rise) || (evt.mode == EVT_NPULSE && fall)) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt.count <= '0;
    end else if (evt.enable && hit) begin
      evt.count <= evt.count + 16'h0001;
    end
  end

endmodule : bga_evt_counter
`default_nettype wire

// ### rtl/bga_clk_div.sv
/*
  Clock output generator: 24 MHz / divider synthesised from the core
  clock with a phase accumulator. Assumes i_clk at CLK_MHZ.
*/
`timescale 1ns/1ps
`default_nettype none
module bga_clk_div (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_run,
  input  wire logic [bga_pkg::DIV_W-1:0] i_div,
  output var  logic             o_clk_out
);
  import bga_pkg::*;

  localparam logic [ACC_W-1:0] STEP = ACC_W'(2 * REF_MHZ);

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] thr;
  logic [ACC_W-1:0] next_acc;

  // divider zero means 256; one toggle per core cycle caps out at 10 MHz
  assign thr = (i_div == 8'h00) ? ACC_W'(DIV_ZERO_EQ * CLK_MHZ)
                                : ACC_W'(i_div) * ACC_W'(CLK_MHZ);
  assign next_acc = acc + STEP;

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      acc       <= '0;
      o_clk_out <= 1'b0;
    end else if (next_acc >= thr) begin
      acc       <= next_acc - thr;
      o_clk_out <= ~o_clk_out;
    end else begin
      acc       <= next_acc;
    end
  end

endmodule : bga_clk_div
`default_nettype wire

// ### sim/bga_gpio_checker.sv
/*
  Port assertions for the GPIO alternate-function top.
  Assumes the bind at the foot and resets held two cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module bga_gpio_checker #(
  parameter int WAKE_CYCLES = 20
) (
  input wire logic                       i_clk,
  input wire logic                       i_rst,
  input wire logic                       i_read_cmd,
  input wire logic                       i_flow_en,
  input wire logic                       i_spi_busy,
  input wire logic                       i_enumerated,
  input wire logic                       i_suspend,
  input wire logic                       i_evt_query,
  input wire logic                       i_otp_wr,
  input wire logic [3:0]                 i_otp_item,
  input wire logic [bga_pkg::NPIN-1:0]   o_gpio_out,
  input wire logic                       o_read_clock_ok,
  input wire logic [bga_pkg::CNT_W-1:0]  o_evt_value,
  input wire logic                       o_evt_valid,
  input wire logic                       o_remote_wake,
  input wire logic                       o_otp_accept,
  input wire logic                       o_otp_reject,
  input wire logic [bga_pkg::NGROUP-1:0] o_otp_locked
);
  import bga_pkg::*;
  logic [15:0] wake_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst) wake_cnt <= 16'h0000;
    else wake_cnt <= o_remote_wake ? wake_cnt + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_gate_idle_open: assert property (!(i_read_cmd && i_flow_en) |=> o_read_clock_ok)
    else $error("read clock held off outside gated read");
  a_query_answer: assert property (o_evt_valid == $past(i_evt_query))
    else $error("count answer pulse wrong");
  a_count_hold: assert property (!o_evt_valid |-> $stable(o_evt_value))
    else $error("count value moved without query");
  a_otp_one_answer: assert property (i_otp_wr |=> o_otp_accept != o_otp_reject)
    else $error("config write not answered once");
  a_otp_quiet: assert property (!i_otp_wr |=> !o_otp_accept && !o_otp_reject)
    else $error("config answer without write");
  a_otp_group_lock: assert property (i_otp_wr && (i_otp_item > 4'h8 || (o_otp_locked[0] && i_otp_item < 4'h4))
    |=> o_otp_reject) else $error("locked or bad item accepted");
  a_lock_only_accept: assert property ((o_otp_locked & ~$past(o_otp_locked)) != 3'b000 |-> o_otp_accept)
    else $error("group locked without accepted write");
  a_wake_in_susp: assert property ($rose(o_remote_wake) |-> $past(i_suspend))
    else $error("wakeup outside suspend");
  a_wake_length: assert property ($fell(o_remote_wake) |-> wake_cnt == WAKE_CYCLES)
    else $error("wakeup length wrong");
  a_clk_pin_off: assert property ((!i_enumerated || i_suspend)[*3] |-> !o_gpio_out[5])
    else $error("clock pin active while off");
  a_act_idle_high: assert property ((!i_spi_busy && !i_suspend)[*3] |-> o_gpio_out[8])
    else $error("activity pin low while idle");
  a_susp_pins_awake: assert property (!i_suspend |=> !o_gpio_out[9] && o_gpio_out[10])
    else $error("suspend pins wrong while awake");
endmodule : bga_gpio_checker
bind bga_gpio_top bga_gpio_checker #(.WAKE_CYCLES(WAKE_CYCLES)) i_bga_gpio_checker (.*);
`default_nettype wire

// ### sim/bga_pin_model.sv
/*
  Board model on the pins: slave ready line, event and wake sources.
  Assumes levels come from the bench; pins the device drives read back.
*/
`timescale 1ns/1ps
`default_nettype none
module bga_pin_model (
  input  wire logic                     i_clk,
  input  wire logic [bga_pkg::NPIN-1:0] i_out,
  input  wire logic [bga_pkg::NPIN-1:0] i_oe,
  input  wire logic [bga_pkg::NPIN-1:0] i_lvl,
  input  wire logic                     i_rdy,
  input  wire logic                     i_rdy_high,
  input  wire logic                     i_slow,
  output var  logic [bga_pkg::NPIN-1:0] o_pin
);
  import bga_pkg::*;
  logic [3:0] rdy_dly;
  logic       rdy_now;
  // a slow slave raises ready four cycles late
  always_ff @(posedge i_clk) begin
    rdy_dly <= {rdy_dly[2:0], i_rdy};
  end
  assign rdy_now = i_slow ? rdy_dly[3] : i_rdy;
  always_comb begin
    o_pin = (i_oe & i_out) | (~i_oe & i_lvl);
    if (!i_oe[3]) o_pin[3] = i_rdy_high ? rdy_now : !rdy_now;
  end
endmodule : bga_pin_model
`default_nettype wire

// ### sim/tb_bga_gpio_top.sv
/*
  Bench for the GPIO alternate-function top: gating, event modes, clock,
  activity, suspend, wakeup, override and configuration locking.
  Assumes the pin model on every pin and the checker bound in.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_bga_gpio_top;
  import bga_pkg::*;
  localparam int WAKE = 20;
  logic              i_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_read_cmd = 1'b0, i_flow_en = 1'b0, i_spi_busy = 1'b0, i_enumerated = 1'b0;
  logic              i_suspend = 1'b0, i_evt_query = 1'b0, i_otp_wr = 1'b0;
  logic              rdy = 1'b0, rdy_high = 1'b0, slow = 1'b0;
  logic              o_read_clock_ok, o_evt_valid, o_remote_wake, o_otp_accept, o_otp_reject;
  logic [3:0]        i_otp_item = 4'h0;
  logic [15:0]       i_otp_data = 16'h0000;
  logic [NPIN-1:0]   i_gpio, o_gpio_out, o_gpio_oe;
  logic [NPIN-1:0]   i_gpio_latch = 11'h055;
  logic [NPIN-1:0]   lvl = 11'h000;
  logic [CNT_W-1:0]  o_evt_value;
  logic [NGROUP-1:0] o_otp_locked;
  int                err_total = 0;
  int                tests_run = 0;
  int                c;
  initial forever #25 i_clk = ~i_clk;
  bga_gpio_top #(.WAKE_CYCLES(WAKE), .ACT_CYCLES(4)) i_bga_gpio_top (.*);
  bga_pin_model i_bga_pin_model (.i_clk(i_clk), .i_out(o_gpio_out), .i_oe(o_gpio_oe), .i_lvl(lvl),
    .i_rdy(rdy), .i_rdy_high(rdy_high), .i_slow(slow), .o_pin(i_gpio));
  task automatic stop_test;
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  task automatic reset_dut;
    i_rst = 1'b1;
    tick(2);
    i_rst = 1'b0;
  endtask : reset_dut
  task automatic otp(input logic [3:0] item, input logic [15:0] data, input logic acc);
    i_otp_wr = 1'b1;
    i_otp_item = item;
    i_otp_data = data;
    tick(1);
    i_otp_wr = 1'b0;
    check(o_otp_accept, acc);
    check(o_otp_reject, !acc);
    // one idle edge so a following call never re-raises the strobe in this step
    tick(1);
  endtask : otp
  task automatic query(input logic [15:0] exp);
    i_evt_query = 1'b1;
    tick(1);
    i_evt_query = 1'b0;
    check(o_evt_valid, 1'b1);
    check(o_evt_value, exp);
  endtask : query
  // bounded: slow slave plus pin synchroniser stays well under 20
  task automatic wait_gate(input logic exp);
    int n;
    n = 0;
    while (o_read_clock_ok !== exp && n < 20) begin
      tick(1);
      n++;
    end
    check(o_read_clock_ok, exp);
    if (n == 20) stop_test;
  endtask : wait_gate
  task automatic toggles(input int idx, input int n, output int cnt);
    logic last;
    cnt = 0;
    last = o_gpio_out[idx];
    repeat (n) begin
      tick(1);
      if (o_gpio_out[idx] !== last) cnt++;
      last = o_gpio_out[idx];
    end
  endtask : toggles
  initial begin
    #1000000;
    check(1'b0, 1'b1);
    stop_test;
  end
  initial begin
    for (int m = 0; m < 4; m++) begin
      rdy_high = m[0];
      slow = m[1];
      reset_dut;
      otp(ITEM_OPT, 16'(m * 2 + m % 2), 1'b1);
      otp(ITEM_FUNC, 16'h0738, 1'b0);
      i_read_cmd = 1'b1;
      tick(4);
      check(o_read_clock_ok, 1'b1);
      i_flow_en = 1'b1;
      wait_gate(1'b0);
      rdy = 1'b1;
      wait_gate(1'b1);
      i_read_cmd = 1'b0;
      i_flow_en = 1'b0;
      rdy = 1'b0;
      repeat (3) begin
        lvl[PIN_EVT] = 1'b1;
        tick(4);
        lvl[PIN_EVT] = 1'b0;
        tick(4);
      end
      // idle low: a negative pulse needs its leading fall first
      query(m == 3 ? 16'h0002 : 16'h0003);
    end
    reset_dut;
    toggles(PIN_CLK, 100, c);
    check(16'(c), 16'h0000);
    i_enumerated = 1'b1;
    tick(4);
    toggles(PIN_CLK, 3200, c);
    check(c >= 29 && c <= 31, 1'b1);
    otp(ITEM_DIV, 16'h0018, 1'b1);
    toggles(PIN_CLK, 3200, c);
    check(c >= 319 && c <= 321, 1'b1);
    check(o_gpio_out[PIN_ACT], 1'b1);
    i_spi_busy = 1'b1;
    toggles(PIN_ACT, 40, c);
    check(c >= 9 && c <= 11, 1'b1);
    i_spi_busy = 1'b0;
    i_suspend = 1'b1;
    tick(4);
    check(o_gpio_out[PIN_SUSP], 1'b1);
    check(o_gpio_out[PIN_NSUSP], 1'b0);
    toggles(PIN_CLK, 100, c);
    check(16'(c), 16'h0000);
    otp(ITEM_WMASK, 16'h0040, 1'b1);
    otp(ITEM_WVAL, 16'h0040, 1'b0);
    check(o_otp_locked, 3'b110);
    lvl[6] = 1'b1;
    c = 0;
    while (o_remote_wake !== 1'b1 && c < 10) begin
      tick(1);
      c++;
    end
    check(c < 10, 1'b1);
    if (c == 10) stop_test;
    c = 0;
    while (o_remote_wake === 1'b1 && c < 40) begin
      tick(1);
      c++;
    end
    check(16'(c), 16'(WAKE));
    i_suspend = 1'b0;
    lvl[6] = 1'b0;
    reset_dut;
    otp(ITEM_OPT, 16'h0008, 1'b1);
    otp(ITEM_SLATCH, 16'h00C3, 1'b1);
    otp(ITEM_SMODE, 16'h07FF, 1'b0);
    otp(4'h9, 16'h0000, 1'b0);
    i_suspend = 1'b1;
    tick(3);
    check(o_gpio_out, 11'h0C3);
    check(o_gpio_oe, 11'h73C);
    i_suspend = 1'b0;
    tick(3);
    check(o_gpio_oe, 11'h7A7);
    stop_test;
  end
endmodule : tb_bga_gpio_top
`default_nettype wire
